// file: irq_defs.svh
// How it works
// - enable-2 holds eight source enables, oscfail first
// - one enables source, zero blocks; peripheral enable also needed
// - enable-4 bits 7..4: pwm 4..1 time-base enables
// - enable-4 bits 3..0: pwm 4..1 shutdown enables
// - request-1 holds eight flags, timer1 gate first
// - serial rx and tx flags read-only, rest writable
// - flag reads one while pending, else zero
// - flag sets regardless of enables
// - all enables and flags reset to zero
// - timer2 flag marks timer2 period match
// - global enable gates the core interrupt request, not the block irq
// - peripheral enable gates peripheral interrupts
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define OFF_CORE_CTL 8'h00
`define OFF_ENABLE_2 8'h04
`define OFF_ENABLE_4 8'h08
`define OFF_REQUEST_1 8'h0c
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define GLOBAL_EN_BIT 7
`define PERIPH_EN_BIT 6
`define RX_FLAG_BIT 5
`define TX_FLAG_BIT 4
`define T2_FLAG_BIT 1
`define T1OVF_FLAG_BIT 0
`define REQ1_RO_MASK 8'h30
`define REG8_RESET 8'h00
`define STAT_RESET 3'h0
`define STAT_FLAG_NEW 0
`define STAT_RO_WRITE 1
`define STAT_BAD_ADDR 2

`endif

// file: irq_flag_bank.sv
`timescale 1ns/10ps
`include "irq_defs.svh"
module irq_flag_bank #(
   parameter logic [7:0] HW_MASK = `REQ1_RO_MASK
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] src,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] flags_q
);

   // -----------------------------------------------------------------
   // one flag per bit
   // -----------------------------------------------------------------
   wire logic [7:0] flags_d;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_flag
         if (HW_MASK[i]) begin : g_ro
            // read-only flag mirrors its source level
            assign flags_d[i] = src[i];
         end else begin : g_rw
            // source pulse sets; a write in the same cycle loses
            assign flags_d[i] = src[i]
                                | (wr_en ? wr_data[i] : flags_q[i]);
         end
      end
   endgenerate

   // one register for the whole bank, cleared on reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_q <= `REG8_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

endmodule // irq_flag_bank

// file: irq_pkg.sv
package irq_pkg;

   // one bit per request-1 source, in register order
   typedef struct packed {
      logic timer1_gate;
      logic adc_done;
      logic serial_rx;
      logic serial_tx;
      logic sync_serial;
      logic capcmp1;
      logic timer2_match;
      logic timer1_overflow;
   } req1_src_t;

   // control bits of the core control register
   typedef struct packed {
      logic global_irq_en;
      logic periph_irq_en;
   } core_ctl_t;

endpackage

// file: periph_event_model.sv
`timescale 1ns/10ps
module periph_event_model
   import irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic [7:0] fire,
   input wire logic rx_level,
   input wire logic tx_level,
   output req1_src_t req1_src
);
   logic [7:0] fire_q = 8'h00;
   logic [7:0] pulse_q = 8'h00;

   // -------------------------------------------------
   // event sources
   // -------------------------------------------------
   // one-cycle set pulse on each rising command bit
   always_ff @(posedge core_clk) begin
      fire_q <= fire;
      pulse_q <= fire & ~fire_q;
   end

   // serial flags follow their source levels
   always_comb begin
      req1_src = pulse_q;
      req1_src.serial_rx = rx_level;
      req1_src.serial_tx = tx_level;
   end
endmodule // periph_event_model

// file: periph_irq_ctrl.sv
`timescale 1ns/10ps
`include "irq_defs.svh"
module periph_irq_ctrl
   import irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // request-1 sources: pulses, serial bits are levels
   input wire req1_src_t req1_src,
   // enables and flags held by neighbouring registers
   input wire logic [7:0] enable_1,
   input wire logic [7:0] request_2,
   input wire logic [7:0] request_4,
   // enables to neighbours and request to the core
   output logic [7:0] enable_2,
   output logic [7:0] enable_4,
   output logic [7:0] request_1,
   output logic core_irq_req,
   output logic irq
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   core_ctl_t core_ctl_q;
   logic [7:0] enable_2_q;
   logic [7:0] enable_4_q;
   logic [7:0] request_1_q;
   logic [7:0] request_1_prev_q;
   logic [2:0] status_q;
   logic [2:0] mask_q;
   logic [31:0] prdata_q;
   logic core_irq_req_q;
   logic irq_q;

   // -----------------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------------
   logic setup_ph;
   logic access_ph;
   logic wr_acc;
   logic addr_ok;
   logic hit_ctl;
   logic hit_en2;
   logic hit_en4;
   logic hit_req1;
   logic hit_stat;
   logic hit_mask;

   // address compare against each register
   assign hit_ctl = (paddr == `OFF_CORE_CTL);
   assign hit_en2 = (paddr == `OFF_ENABLE_2);
   assign hit_en4 = (paddr == `OFF_ENABLE_4);
   assign hit_req1 = (paddr == `OFF_REQUEST_1);
   assign hit_stat = (paddr == `OFF_IRQ_STATUS);
   assign hit_mask = (paddr == `OFF_IRQ_MASK);
   assign addr_ok = hit_ctl | hit_en2 | hit_en4 | hit_req1 | hit_stat
                    | hit_mask;

   // zero wait states; error on unmapped address
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign wr_acc = access_ph & pwrite & addr_ok;
   assign pready = access_ph;
   assign pslverr = access_ph & ~addr_ok;

   // -----------------------------------------------------------------
   // read data, captured in the setup phase
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph & ~pwrite) begin
         case (1'b1)
            hit_ctl: prdata_q <= {24'h00_0000, core_ctl_q, 6'h00};
            hit_en2: prdata_q <= {24'h00_0000, enable_2_q};
            hit_en4: prdata_q <= {24'h00_0000, enable_4_q};
            hit_req1: prdata_q <= {24'h00_0000, request_1_q};
            hit_stat: prdata_q <= {29'h0000_0000, status_q};
            hit_mask: prdata_q <= {29'h0000_0000, mask_q};
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign prdata = prdata_q;

   // -----------------------------------------------------------------
   // core control: global and peripheral enables
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         core_ctl_q <= 2'h0;
      end else if (wr_acc & hit_ctl) begin
         core_ctl_q.global_irq_en <= pwdata[`GLOBAL_EN_BIT];
         core_ctl_q.periph_irq_en <= pwdata[`PERIPH_EN_BIT];
      end
   end

   // -----------------------------------------------------------------
   // enable registers
   // -----------------------------------------------------------------
   // bit 7 osc fail down to bit 0 capture/compare 2
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enable_2_q <= `REG8_RESET;
      end else if (wr_acc & hit_en2) begin
         enable_2_q <= pwdata[7:0];
      end
   end

   // time-base enables high nibble, shutdown enables low nibble
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enable_4_q <= `REG8_RESET;
      end else if (wr_acc & hit_en4) begin
         enable_4_q[7:4] <= pwdata[7:4];
         enable_4_q[3:0] <= pwdata[3:0];
      end
   end
   assign enable_2 = enable_2_q;
   assign enable_4 = enable_4_q;

   // -----------------------------------------------------------------
   // request-1 flags
   // -----------------------------------------------------------------
   // serial bits follow their sources, others set by pulses
   irq_flag_bank #(
      .HW_MASK(`REQ1_RO_MASK)
   ) u_req1 (
      .core_clk(core_clk),
      .rst(rst),
      .src(req1_src),
      .wr_en(wr_acc & hit_req1),
      .wr_data(pwdata[7:0]),
      .flags_q(request_1_q)
   );
   assign request_1 = request_1_q;

   // -----------------------------------------------------------------
   // request to the core
   // -----------------------------------------------------------------
   logic periph_pending;

   // any flag whose own enable is set
   assign periph_pending = |(request_1_q & enable_1)
                           | |(request_2 & enable_2_q)
                           | |(request_4 & enable_4_q);

   // gated by peripheral and global enables
   always_ff @(posedge core_clk) begin
      if (rst) begin
         core_irq_req_q <= 1'b0;
      end else begin
         core_irq_req_q <= periph_pending
                           & core_ctl_q.periph_irq_en
                           & core_ctl_q.global_irq_en;
      end
   end
   assign core_irq_req = core_irq_req_q;

   // -----------------------------------------------------------------
   // block interrupt: sticky status, mask, level output
   // -----------------------------------------------------------------
   logic [2:0] stat_evt;

   // events: new flag, write to read-only flag, bad address
   always_ff @(posedge core_clk) begin
      if (rst) begin
         request_1_prev_q <= `REG8_RESET;
      end else begin
         request_1_prev_q <= request_1_q;
      end
   end
   assign stat_evt[`STAT_FLAG_NEW] = |(request_1_q & ~request_1_prev_q);
   assign stat_evt[`STAT_RO_WRITE] = wr_acc & hit_req1
                                     & |(pwdata[7:0] & `REQ1_RO_MASK);
   assign stat_evt[`STAT_BAD_ADDR] = pslverr;

   // write one to clear; a new event wins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_q <= `STAT_RESET;
      end else if (wr_acc & hit_stat) begin
         status_q <= (status_q & ~pwdata[2:0]) | stat_evt;
      end else begin
         status_q <= status_q | stat_evt;
      end
   end

   // mask, one enables the status bit onto irq
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mask_q <= `STAT_RESET;
      end else if (wr_acc & hit_mask) begin
         mask_q <= pwdata[2:0];
      end
   end

   // registered level interrupt
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end
   assign irq = irq_q;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // a timer1 overflow pulse while everything is enabled
   sequence s_t1ovf_enabled;
      req1_src.timer1_overflow && enable_1[`T1OVF_FLAG_BIT]
         && core_ctl_q.global_irq_en && core_ctl_q.periph_irq_en;
   endsequence

   // enables stay on for the following cycle
   sequence s_still_enabled;
      enable_1[`T1OVF_FLAG_BIT] && core_ctl_q.global_irq_en
         && core_ctl_q.periph_irq_en;
   endsequence

   chk_enable2_write: assert property (
      wr_acc && hit_en2 |=> enable_2_q == $past(pwdata[7:0])
   ) else $error("enable 2 did not take write data");

   chk_enable4_read: assert property (
      setup_ph && !pwrite && hit_en4 && !wr_acc
      |=> prdata == {24'h00_0000, $past(enable_4_q)}
   ) else $error("enable 4 read data wrong");

   chk_serial_readonly: assert property (
      ##1 request_1_q[`RX_FLAG_BIT:`TX_FLAG_BIT]
         == $past({req1_src.serial_rx, req1_src.serial_tx})
   ) else $error("serial flags not following source");

   chk_flag_sets: assert property (
      req1_src.capcmp1 |=> request_1_q[2] [*1]
   ) else $error("flag not set by its event");

   chk_timer2_flag: assert property (
      req1_src.timer2_match |=> request_1_q[`T2_FLAG_BIT]
   ) else $error("timer2 match flag not set");

   chk_reset_zero: assert property (@(posedge core_clk)
      disable iff (1'b0)
      rst |=> enable_2_q == `REG8_RESET
         && enable_4_q == `REG8_RESET && core_ctl_q == 2'h0
         && (request_1_q & ~`REQ1_RO_MASK) == `REG8_RESET
   ) else $error("registers not zero after reset");

   chk_global_block: assert property (
      !core_ctl_q.global_irq_en |=> !core_irq_req
   ) else $error("request while global enable clear");

   chk_periph_block: assert property (
      !core_ctl_q.periph_irq_en |=> !core_irq_req
   ) else $error("request while peripheral enable clear");

   chk_core_request: assert property (
      s_t1ovf_enabled ##1 s_still_enabled |=> core_irq_req
   ) else $error("core request missing two cycles after event");

   chk_irq_level: assert property (
      |(status_q & mask_q) |=> irq ##0 $past(status_q != 3'h0)
   ) else $error("irq not raised by unmasked status");

   chk_ro_write_ignored: assert property (
      wr_acc && hit_req1 && !req1_src.serial_rx
      |=> !request_1_q[`RX_FLAG_BIT]
   ) else $error("serial receive flag took a write");

   chk_flag_write_clear: assert property (
      wr_acc && hit_req1 && !pwdata[`T2_FLAG_BIT]
         && !req1_src.timer2_match
      |=> !request_1_q[`T2_FLAG_BIT]
   ) else $error("timer2 flag not cleared by write");

   chk_enable4_write: assert property (
      wr_acc && hit_en4 |=> enable_4_q == $past(pwdata[7:0])
   ) else $error("enable 4 did not take write data");

   chk_request_source: assert property (
      core_irq_req |-> $past(periph_pending)
   ) else $error("core request without an enabled flag");

   chk_status_sticky: assert property (
      pslverr |=> status_q[`STAT_BAD_ADDR]
   ) else $error("bad address not recorded in status");

   chk_status_clear: assert property (
      wr_acc && hit_stat && pwdata[`STAT_BAD_ADDR]
         && !stat_evt[`STAT_BAD_ADDR]
      |=> !status_q[`STAT_BAD_ADDR]
   ) else $error("status bit not cleared by write");

endmodule // periph_irq_ctrl

// file: peripheral_irq_enable_flags_tb_top.sv
`timescale 1ns/10ps
`include "irq_defs.svh"
module peripheral_irq_enable_flags_tb_top
   import irq_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] enable_1 = 8'h00;
   logic [7:0] request_2 = 8'h00;
   logic [7:0] request_4 = 8'h00;
   logic [7:0] fire = 8'h00;
   logic rx_level = 1'b0;
   logic tx_level = 1'b0;
   req1_src_t req1_src;
   logic [7:0] enable_2;
   logic [7:0] enable_4;
   logic [7:0] request_1;
   logic core_irq_req;
   logic irq;
   logic [31:0] rd_v;
   logic err_v;
   int fail_count = 0;
   int n_checks = 0;

   // -------------------------------------------------
   // clock, partner and device
   // -------------------------------------------------
   always #2.5 core_clk = ~core_clk;

   periph_event_model src_model (.core_clk(core_clk), .fire(fire),
      .rx_level(rx_level), .tx_level(tx_level), .req1_src(req1_src));

   periph_irq_ctrl DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req1_src(req1_src), .enable_1(enable_1),
      .request_2(request_2), .request_4(request_4),
      .enable_2(enable_2), .enable_4(enable_4), .request_1(request_1),
      .core_irq_req(core_irq_req), .irq(irq));

   // -------------------------------------------------
   // tasks
   // -------------------------------------------------
   task automatic conclude();
      $display("mismatches %0d checks %0d", fail_count, n_checks);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         conclude();
      end
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_v, {24'h0, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic pulse(input logic [7:0] m);
      fire <= m;
      @(posedge core_clk);
      fire <= 8'h00;
      cyc(2);
   endtask

   // -------------------------------------------------
   // main sequence
   // -------------------------------------------------
   initial begin
      cyc(5);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 6; i++) begin
         rdc(8'(4 * i), 8'h00);
      end
      chk({core_irq_req, irq}, 32'h0);
      wr(`OFF_ENABLE_2, 8'ha5);
      rdc(`OFF_ENABLE_2, 8'ha5);
      chk(enable_2, 32'ha5);
      wr(`OFF_ENABLE_4, 8'h5a);
      rdc(`OFF_ENABLE_4, 8'h5a);
      chk(enable_4, 32'h5a);
      wr(`OFF_REQUEST_1, 8'hff);
      rdc(`OFF_REQUEST_1, 8'hcf);
      wr(`OFF_REQUEST_1, 8'h00);
      rdc(`OFF_REQUEST_1, 8'h00);
      pulse(8'h02);
      rdc(`OFF_REQUEST_1, 8'h02);
      chk(core_irq_req, 32'h0);
      // stale flag cleared before enabling it
      wr(`OFF_REQUEST_1, 8'h00);
      enable_1 <= 8'h02;
      wr(`OFF_CORE_CTL, 8'hc0);
      pulse(8'h02);
      cyc(2);
      chk(core_irq_req, 32'h1);
      wr(`OFF_CORE_CTL, 8'h40);
      cyc(3);
      chk(core_irq_req, 32'h0);
      wr(`OFF_CORE_CTL, 8'h80);
      cyc(3);
      chk(core_irq_req, 32'h0);
      wr(`OFF_REQUEST_1, 8'h00);
      wr(`OFF_CORE_CTL, 8'hc0);
      request_2 <= 8'h80;
      cyc(3);
      chk(core_irq_req, 32'h1);
      wr(`OFF_ENABLE_2, 8'h7f);
      cyc(3);
      chk(core_irq_req, 32'h0);
      request_2 <= 8'h00;
      request_4 <= 8'h01;
      cyc(3);
      chk(core_irq_req, 32'h0);
      wr(`OFF_ENABLE_4, 8'h01);
      cyc(3);
      chk(core_irq_req, 32'h1);
      request_4 <= 8'h00;
      rx_level <= 1'b1;
      cyc(3);
      rdc(`OFF_REQUEST_1, 8'h20);
      rx_level <= 1'b0;
      cyc(3);
      rdc(`OFF_REQUEST_1, 8'h00);
      // timer1 overflow and capture/compare 1 in one cycle
      enable_1 <= 8'h01;
      pulse(8'h05);
      cyc(1);
      chk(request_1, 32'h05);
      chk(core_irq_req, 32'h1);
      wr(`OFF_REQUEST_1, 8'h00);
      apb(1'b0, 8'h1c, 32'h0);
      chk({err_v, rd_v[30:0]}, 32'h80000000);
      rdc(`OFF_IRQ_STATUS, 8'h07);
      chk(irq, 32'h0);
      wr(`OFF_IRQ_MASK, 8'h04);
      cyc(2);
      chk(irq, 32'h1);
      wr(`OFF_IRQ_STATUS, 8'h04);
      cyc(2);
      chk(irq, 32'h0);
      rdc(`OFF_IRQ_STATUS, 8'h03);
      // second reset in mid-run clears everything again
      rst <= 1'b1;
      cyc(3);
      rst <= 1'b0;
      @(posedge core_clk);
      rdc(`OFF_ENABLE_2, 8'h00);
      rdc(`OFF_ENABLE_4, 8'h00);
      rdc(`OFF_CORE_CTL, 8'h00);
      chk(request_1, 32'h0);
      chk({core_irq_req, irq}, 32'h0);
      conclude();
   end
endmodule // peripheral_irq_enable_flags_tb_top
